// *** verilog/tapm_top.sv ***
// Contract
// - Count source is undivided, divide-by-8, divide-by-32 or sub-clock divided by 32.
// - Counter counts down, as an 8-bit or 16-bit modulator by software choice.
// - Each pulse rising edge reloads the counter from the reload register; counting continues.
// - Triggers arriving while counting are ignored.
// - 16-bit: high time n source periods, cycle fixed at 65535 periods.
// - 8-bit: high time n times (m+1) periods, n from upper byte.
// - 8-bit: cycle 255 times (m+1) periods, m from lower byte.
// - Gated start begins on trigger pin edge or other timer overflow.
// - Start flag set to 1 enables counting; ungated start is immediate.
// - Start flag cleared to 0 stops counter and pulse generation.
// - Interrupt request raised at each falling edge of the pulse.
// - Trigger pin is general input or trigger; output pin carries the pulse.
// - Reading the timer register returns an undefined value, not the count.
// - Timer write while stopped loads both reload register and counter.
// - Timer write while counting loads reload register only, used at next reload.
`timescale 1ns/100ps
`default_nettype none
module tapm_top (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        subclock_tick,
    input  wire logic        trigger_input_pin,
    input  wire logic        other_timer_overflow,
    output logic             pulse_output_pin,
    output logic             irq_request
);
    tapm_tick_if tk ();

    logic [tapm_pkg::CTRL_W-1:0] ctrl_q;
    logic [15:0]                 reload_q;
    logic [15:0]                 act_q;
    logic [15:0]                 dn_q;
    logic [7:0]                  pre_q;
    tapm_pkg::tapm_state_e       state_q;
    logic                        trig_prev_q;
    logic                        wr_fire;
    logic                        rd_fire;
    logic                        wr_ctrl;
    logic                        wr_timer;
    logic [15:0]                 wr_val;
    logic                        w8;
    logic [15:0]                 last;
    logic [7:0]                  m_act;
    logic [15:0]                 n_act;
    logic [7:0]                  m_new;
    logic [15:0]                 pos;
    logic                        trig_edge;
    logic                        trig_evt;
    logic                        run_start;
    logic                        running;
    logic                        wrap;
    logic                        pulse_d;

    // The prescaler turns the selected count source into a one-cycle tick enable.
    tapm_prescaler i_tapm_prescaler (
        .mclk          (mclk),
        .rst           (rst),
        .subclock_tick (subclock_tick),
        .tk            (tk.gen)
    );

    assign tk.sel = tapm_pkg::tapm_src_e'(ctrl_q[tapm_pkg::CTRL_SRC +: 2]);

    // Both address and data must be present; waiting for both lets the master
    // offer them in either order without any skid storage here.
    assign wr_fire  = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
    assign rd_fire  = s_axi_arready && s_axi_arvalid;
    assign wr_ctrl  = wr_fire && (s_axi_awaddr == tapm_pkg::OFF_CTRL);
    assign wr_timer = wr_fire && (s_axi_awaddr == tapm_pkg::OFF_TIMER);
    assign wr_val[7:0]  = s_axi_wstrb[0] ? s_axi_wdata[7:0] : reload_q[7:0];
    assign wr_val[15:8] = s_axi_wstrb[1] ? s_axi_wdata[15:8] : reload_q[15:8];

    // Both widths share one down counter; only the start value and step length differ.
    assign w8      = ctrl_q[tapm_pkg::CTRL_W8];
    assign last    = w8 ? tapm_pkg::LAST8 : tapm_pkg::LAST16;
    assign m_act   = w8 ? act_q[7:0] : 8'h00;
    assign n_act   = w8 ? {8'h00, act_q[15:8]} : act_q;
    assign m_new   = w8 ? reload_q[7:0] : 8'h00;
    // Position counts steps from the start of the period, as the counter runs down.
    assign pos     = last - dn_q;
    assign running = state_q == tapm_pkg::S_RUN;
    // A wrap is the last tick of the last step; the wrap itself starts a new high phase.
    assign wrap    = running && tk.tick && (pre_q == 8'h00) && (dn_q == 16'h0000);
    // The comparison is shared so the pin and the interrupt can never disagree.
    assign pulse_d = running && (pos < n_act);

    // Inputs are synchronous to mclk, so one flop is enough for edge detection.
    assign trig_edge = ctrl_q[tapm_pkg::CTRL_TPOL] ? (trigger_input_pin && !trig_prev_q)
                                                   : (!trigger_input_pin && trig_prev_q);
    assign trig_evt  = ctrl_q[tapm_pkg::CTRL_TSRC] ? other_timer_overflow : trig_edge;
    assign run_start = ctrl_q[tapm_pkg::CTRL_START] &&
                       (((state_q == tapm_pkg::S_IDLE) && !ctrl_q[tapm_pkg::CTRL_GATE]) ||
                        ((state_q == tapm_pkg::S_WAIT) && trig_evt));

    // Reset leaves the previous sample low, so a falling-edge trigger cannot fire
    // falsely after reset; a pin already high may look like a rising edge.
    always_ff @(posedge mclk)
    begin
        if (rst)
            trig_prev_q <= 1'b0;
        else
            trig_prev_q <= trigger_input_pin;
    end

    // Control lives in byte lane 0 only; a write without that strobe leaves it alone.
    always_ff @(posedge mclk)
    begin
        if (rst)
            ctrl_q <= tapm_pkg::CTRL_RESET;
        else if (wr_ctrl && s_axi_wstrb[0])
            ctrl_q <= s_axi_wdata[tapm_pkg::CTRL_W-1:0];
    end

    // The reload register always takes the written value; only the active copy
    // below cares whether the channel is counting.
    always_ff @(posedge mclk)
    begin
        if (rst)
            reload_q <= tapm_pkg::TIMER_RESET;
        else if (wr_timer)
            reload_q <= wr_val;
    end

    // Clearing the start flag wins over every state, so a stop is never lost to a
    // trigger that arrives in the same cycle.
    always_ff @(posedge mclk)
    begin
        if (rst)
            state_q <= tapm_pkg::S_IDLE;
        else if (!ctrl_q[tapm_pkg::CTRL_START])
            state_q <= tapm_pkg::S_IDLE;
        else
        begin
            case (state_q)
                tapm_pkg::S_IDLE:
                    state_q <= run_start ? tapm_pkg::S_RUN : tapm_pkg::S_WAIT;
                tapm_pkg::S_WAIT:
                    if (run_start)
                        state_q <= tapm_pkg::S_RUN;
                tapm_pkg::S_RUN:
                    state_q <= tapm_pkg::S_RUN;
                default:
                    state_q <= tapm_pkg::S_IDLE;
            endcase
        end
    end

    // The active copy holds the n and m of the period in progress. Writes while
    // counting wait in the reload register, so a period is never cut short.
    always_ff @(posedge mclk)
    begin
        if (rst)
            act_q <= tapm_pkg::TIMER_RESET;
        else if (wr_timer && !running)
            act_q <= wr_val;
        else if (wrap)
            act_q <= reload_q;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            dn_q  <= tapm_pkg::LAST16;
            pre_q <= 8'h00;
        end
        else if (run_start)
        begin
            dn_q  <= last;
            pre_q <= m_act;
        end
        else if (running && tk.tick)
        begin
            if (pre_q != 8'h00)
                pre_q <= pre_q - 8'h01;
            else if (dn_q == 16'h0000)
            begin
                dn_q  <= last;
                pre_q <= m_new;
            end
            else
            begin
                dn_q  <= dn_q - 16'h0001;
                pre_q <= m_act;
            end
        end
    end

    // The pin follows the counter one cycle later; irq is timed off the pin
    // itself so it marks exactly the observed falling edge.
    always_ff @(posedge mclk)
    begin
        if (rst)
            pulse_output_pin <= 1'b0;
        else
            pulse_output_pin <= pulse_d;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            irq_request <= 1'b0;
        else
            irq_request <= pulse_output_pin && !pulse_d;
    end

    // Ready is held off while a response is pending, so a second write cannot
    // overtake the first; this costs two idle cycles between writes.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !s_axi_awready && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
            s_axi_wready  <= !s_axi_awready && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= tapm_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_ctrl || wr_timer || s_axi_awaddr == tapm_pkg::OFF_STATUS)
                            ? tapm_pkg::RESP_OKAY : tapm_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Reads follow the same pattern; rdata is cleared first so unused bits read zero.
    always_ff @(posedge mclk)
    begin
        if (rst)
            s_axi_arready <= 1'b0;
        else
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= tapm_pkg::RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= tapm_pkg::RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            case (s_axi_araddr)
                tapm_pkg::OFF_CTRL:
                    s_axi_rdata[tapm_pkg::CTRL_W-1:0] <= ctrl_q;
                tapm_pkg::OFF_TIMER:
                    // The count is not exposed; software always sees a fixed value.
                    s_axi_rdata <= tapm_pkg::TIMER_RD_VAL;
                tapm_pkg::OFF_STATUS:
                begin
                    s_axi_rdata[tapm_pkg::ST_RUN]   <= running;
                    s_axi_rdata[tapm_pkg::ST_WAIT]  <= state_q == tapm_pkg::S_WAIT;
                    s_axi_rdata[tapm_pkg::ST_PULSE] <= pulse_output_pin;
                    s_axi_rdata[tapm_pkg::ST_PIN]   <= trigger_input_pin;
                end
                default:
                    s_axi_rresp <= tapm_pkg::RESP_SLVERR;
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule
`default_nettype wire

// *** verilog/tapm_pkg.sv ***
`default_nettype none
package tapm_pkg;
    localparam logic [3:0]  OFF_CTRL     = 4'h0;
    localparam logic [3:0]  OFF_TIMER    = 4'h4;
    localparam logic [3:0]  OFF_STATUS   = 4'h8;
    localparam int          CTRL_START   = 0;
    localparam int          CTRL_W8      = 1;
    localparam int          CTRL_SRC     = 2;
    localparam int          CTRL_GATE    = 4;
    localparam int          CTRL_TSRC    = 5;
    localparam int          CTRL_TPOL    = 6;
    localparam int          CTRL_W       = 7;
    localparam logic [6:0]  CTRL_RESET   = 7'h00;
    localparam logic [15:0] TIMER_RESET  = 16'h0000;
    localparam int          ST_RUN       = 0;
    localparam int          ST_WAIT      = 1;
    localparam int          ST_PULSE     = 2;
    localparam int          ST_PIN       = 3;
    localparam logic [15:0] LAST16       = 16'hFFFE;
    localparam logic [15:0] LAST8        = 16'h00FE;
    localparam logic [31:0] TIMER_RD_VAL = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    localparam int          DIV8         = 8;
    localparam int          DIV32        = 32;
    localparam int          SUB_DIV      = 32;

    typedef enum logic [1:0]
    {
        SRC_UNDIV   = 2'b00,
        SRC_DIV8    = 2'b01,
        SRC_DIV32   = 2'b10,
        SRC_SUBDIV  = 2'b11
    } tapm_src_e;

    typedef enum logic [1:0]
    {
        S_IDLE = 2'b00,
        S_WAIT = 2'b01,
        S_RUN  = 2'b10
    } tapm_state_e;
endpackage
`default_nettype wire

// *** verilog/tapm_tick_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface tapm_tick_if;
    tapm_pkg::tapm_src_e sel;
    logic                tick;
    modport ctrl (output sel, input tick);
    modport gen  (input sel, output tick);
endinterface
`default_nettype wire

// *** verilog/tapm_prescaler.sv ***
`timescale 1ns/100ps
`default_nettype none
module tapm_prescaler #(
    parameter int DIV8    = tapm_pkg::DIV8,
    parameter int DIV32   = tapm_pkg::DIV32,
    parameter int SUB_DIV = tapm_pkg::SUB_DIV
) (
    input  wire logic   mclk,
    input  wire logic   rst,
    input  wire logic   subclock_tick,
    tapm_tick_if.gen    tk
);
    localparam int DW = $clog2(DIV32);
    localparam int SW = $clog2(SUB_DIV);
    localparam logic [DW-1:0] D8_LAST  = DW'(DIV8 - 1);
    localparam logic [DW-1:0] D32_LAST = DW'(DIV32 - 1);
    localparam logic [SW-1:0] SUB_LAST = SW'(SUB_DIV - 1);

    logic [DW-1:0] div_q;
    logic [SW-1:0] sub_q;
    logic          d8_en;
    logic          d32_en;
    logic          sub_en;

    // Both fast dividers share one counter, so the divide-by-8 ticks are phase
    // aligned with the divide-by-32 ticks; this needs power-of-two ratios.
    assign d8_en  = (div_q & D8_LAST) == D8_LAST;
    assign d32_en = div_q == D32_LAST;
    assign sub_en = subclock_tick && (sub_q == SUB_LAST);

    always_ff @(posedge mclk)
    begin
        if (rst)
            div_q <= '0;
        else
            div_q <= div_q + DW'(1);
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            sub_q <= '0;
        else if (subclock_tick)
            sub_q <= sub_q + SW'(1);
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            tk.tick <= 1'b0;
        else
        begin
            case (tk.sel)
                tapm_pkg::SRC_UNDIV:  tk.tick <= 1'b1;
                tapm_pkg::SRC_DIV8:   tk.tick <= d8_en;
                tapm_pkg::SRC_DIV32:  tk.tick <= d32_en;
                tapm_pkg::SRC_SUBDIV: tk.tick <= sub_en;
                default:              tk.tick <= 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** sim/tapm_top_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module tapm_asserts (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic        s_axi_rvalid,
    input  wire logic        pulse_output_pin,
    input  wire logic        irq_request
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    logic [3:0] rd_a_q;
    logic [3:0] wr_a_q;
    // Addresses are held so a response can be tied to the request that caused it.
    always_ff @(posedge mclk)
    begin
        if (s_axi_arvalid && s_axi_arready)
            rd_a_q <= s_axi_araddr;
    end
    always_ff @(posedge mclk)
    begin
        if (s_axi_awvalid && s_axi_awready)
            wr_a_q <= s_axi_awaddr;
    end
    property p_irq_fall;
        $fell(pulse_output_pin) |-> ##[0:1] irq_request;
    endproperty
    property p_irq_low;
        irq_request |-> !pulse_output_pin;
    endproperty
    property p_irq_pulse;
        irq_request |=> !irq_request;
    endproperty
    property p_timer_rd;
        s_axi_rvalid && rd_a_q == tapm_pkg::OFF_TIMER |-> s_axi_rdata == tapm_pkg::TIMER_RD_VAL;
    endproperty
    property p_aw_pair;
        s_axi_awready == s_axi_wready;
    endproperty
    property p_b_after;
        s_axi_awvalid && s_axi_awready |=> s_axi_bvalid;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_slverr;
        s_axi_bvalid && wr_a_q > tapm_pkg::OFF_STATUS |-> s_axi_bresp == tapm_pkg::RESP_SLVERR;
    endproperty
    // Reset itself is the cause here, so this one must not be disabled by it.
    property p_rst_low;
        disable iff (1'b0) rst |=> !pulse_output_pin && !irq_request;
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("no irq after pulse fell");
    a_irq_low: assert property (p_irq_low) else $error("irq while pulse high");
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
    a_timer_rd: assert property (p_timer_rd) else $error("timer read shows count");
    a_aw_pair: assert property (p_aw_pair) else $error("awready and wready apart");
    a_b_after: assert property (p_b_after) else $error("write response late");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    a_slverr: assert property (p_slverr) else $error("unmapped write not refused");
    a_rst_low: assert property (p_rst_low) else $error("pulse high after reset");
    c_irq: cover property (irq_request);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == tapm_pkg::RESP_SLVERR);
    c_timer_rd: cover property (s_axi_rvalid && rd_a_q == tapm_pkg::OFF_TIMER);
endmodule
bind tapm_top tapm_asserts i_tapm_asserts (.mclk(mclk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .pulse_output_pin(pulse_output_pin), .irq_request(irq_request));
`default_nettype wire

// *** sim/timer_a_pwm_mode_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module timer_a_pwm_mode_tb;
    logic        mclk, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, sub = 1'b0, trig = 1'b0, ovf = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, pin, irq;
    logic [3:0]  awaddr = 4'h0, wstrb = 4'hF, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bresp, rresp;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    logic [7:0]  cfg[3] = '{8'h33, 8'h53, 8'h13};
    int          n_mismatch, n_compared, cyc, seed, n, m, k, j;
    tapm_top i_tapm_top (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .subclock_tick(sub), .trigger_input_pin(trig), .other_timer_overflow(ovf),
        .pulse_output_pin(pin), .irq_request(irq));
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        bit aw_done;
        bit w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Each channel is released at its own ready; the slave may take them apart.
        while (!(aw_done && w_done))
        begin
            @(posedge mclk);
            if (awready === 1'b1)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        // One idle edge keeps a ready strobe from being lowered and raised in one step.
        @(posedge mclk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [33:0] e);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge mclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        @(posedge mclk);
    endtask
    // The first high phase may start mid-tick, so timing is taken from the first fall.
    task automatic measure(input int hi, input int per);
        int t0;
        int t1;
        do @(posedge mclk); while (pin !== 1'b1);
        do @(posedge mclk); while (pin !== 1'b0);
        t0 = cyc;
        // Both trigger kinds, and both pin edges, while running must change nothing.
        ovf <= 1'b1;
        trig <= ~trig;
        @(posedge mclk);
        ovf <= 1'b0;
        trig <= ~trig;
        do @(posedge mclk); while (pin !== 1'b1);
        t1 = cyc;
        do @(posedge mclk); while (pin !== 1'b0);
        check("irq", 34'(irq), 34'h1);
        check("high time", 34'(cyc - t1), 34'(hi));
        check("period", 34'(cyc - t0), 34'(per));
    endtask
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        sub <= (k == 3) ? 1'b1 : 1'($random(seed));
        if (cyc == 99000)
        begin
            n_mismatch++;
            print_verdict();
        end
        if (bvalid && bready)
            check("bresp", 34'(bresp), 34'(bq.pop_front()));
        if (rvalid && rready)
            check("read", {rresp, rdata}, rq.pop_front());
    end
    initial
    begin
        seed = 49690;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(tapm_pkg::OFF_CTRL, 34'h0);
        rd(tapm_pkg::OFF_STATUS, 34'h0);
        rd(4'hC, {tapm_pkg::RESP_SLVERR, 32'h0});
        wr(4'hC, 32'h1, tapm_pkg::RESP_SLVERR);
        n = 1 + $unsigned($random(seed)) % 20;
        m = $unsigned($random(seed)) % 4;
        wr(tapm_pkg::OFF_TIMER, {16'h0, n[7:0], m[7:0]}, tapm_pkg::RESP_OKAY);
        rd(tapm_pkg::OFF_TIMER, {tapm_pkg::RESP_OKAY, tapm_pkg::TIMER_RD_VAL});
        wr(tapm_pkg::OFF_CTRL, 32'h3, tapm_pkg::RESP_OKAY);
        measure(n * (m + 1), 255 * (m + 1));
        n = 1 + $unsigned($random(seed)) % 20;
        ovf <= 1'b1;
        @(posedge mclk);
        ovf <= 1'b0;
        trig <= 1'b1;
        wr(tapm_pkg::OFF_TIMER, {16'h0, n[7:0], m[7:0]}, tapm_pkg::RESP_OKAY);
        measure(n * (m + 1), 255 * (m + 1));
        wr(tapm_pkg::OFF_CTRL, 32'h0, tapm_pkg::RESP_OKAY);
        rd(tapm_pkg::OFF_STATUS, {tapm_pkg::RESP_OKAY, 32'h8});
        trig <= 1'b0;
        wr(tapm_pkg::OFF_TIMER, 32'h5, tapm_pkg::RESP_OKAY);
        wr(tapm_pkg::OFF_CTRL, 32'h1, tapm_pkg::RESP_OKAY);
        measure(5, 65535);
        wr(tapm_pkg::OFF_CTRL, 32'h0, tapm_pkg::RESP_OKAY);
        wr(tapm_pkg::OFF_TIMER, 32'h0200, tapm_pkg::RESP_OKAY);
        for (k = 1; k < 4; k++)
        begin
            wr(tapm_pkg::OFF_CTRL, 32'(3 | k << 2), tapm_pkg::RESP_OKAY);
            measure(2 * (k == 1 ? 8 : 32), 255 * (k == 1 ? 8 : 32));
            wr(tapm_pkg::OFF_CTRL, 32'h0, tapm_pkg::RESP_OKAY);
        end
        k = 0;
        wr(tapm_pkg::OFF_TIMER, 32'h0400, tapm_pkg::RESP_OKAY);
        for (j = 0; j < 3; j++)
        begin
            trig <= (cfg[j] == 8'h13);
            @(posedge mclk);
            wr(tapm_pkg::OFF_CTRL, {24'h0, cfg[j]}, tapm_pkg::RESP_OKAY);
            rd(tapm_pkg::OFF_STATUS, {tapm_pkg::RESP_OKAY, 28'h0, trig, 3'h2});
            ovf <= (j == 0);
            trig <= (j == 0) ? trig : ~trig;
            @(posedge mclk);
            ovf <= 1'b0;
            measure(4, 255);
            wr(tapm_pkg::OFF_CTRL, 32'h0, tapm_pkg::RESP_OKAY);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
